/* File: dv/smbus_host_model.sv */
`timescale 1ns/1ps
module smbus_host_model #(
    parameter logic [6:0] ADDR = 7'h00
) (
    // clock
    input wire logic clk_sys,
    // bus pins, sda wired-and with the pull-up outside, scl driven directly
    input wire logic sda,
    output logic scl,
    output logic sda_low
);
    // clock stands high and data released between frames
    initial
    begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    // data moves after the slave's turn, one cycle before scl rises
    task automatic bit_io(input logic b, output logic r);
        tick(4);
        sda_low = ~b;
        tick(1);
        scl = 1'h1;
        tick(3);
        r = sda;
        scl = 1'h0;
    endtask
    task automatic start();
        tick(1);
        sda_low = 1'h0;
        tick(4);
        scl = 1'h1;
        tick(4);
        sda_low = 1'h1;
        tick(4);
        scl = 1'h0;
    endtask
    task automatic stop();
        tick(1);
        sda_low = 1'h1;
        tick(4);
        scl = 1'h1;
        tick(4);
        sda_low = 1'h0;
        tick(4);
    endtask
    task automatic byte_out(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(b[i], r);
        bit_io(1'h1, r);
        ack = ~r;
    endtask
    task automatic byte_in(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_io(1'h1, d[i]);
        bit_io(last, r);
    endtask
    task automatic wr(input logic [7:0] cmd, dat, input logic full, output logic ok);
        logic a0, a1, a2;
        a2 = 1'h1;
        start();
        byte_out({ADDR, 1'h0}, a0);
        byte_out(cmd, a1);
        if (full)
            byte_out(dat, a2);
        stop();
        ok = a0 & a1 & a2;
    endtask
    task automatic rd(input logic [7:0] cmd, input logic use_cmd, input int n,
        output logic [15:0] d, output logic ok);
        logic a0, a1;
        a1 = 1'h1;
        d = 16'h0000;
        if (use_cmd)
        begin
            start();
            byte_out({ADDR, 1'h0}, a0);
            byte_out(cmd, a1);
        end
        start();
        byte_out({ADDR, 1'h1}, a0);
        byte_in(n == 1, d[15:8]);
        if (n == 2)
            byte_in(1'h1, d[7:0]);
        stop();
        ok = a0 & a1;
    endtask
endmodule

/* File: dv/test_smbus_temp_sensor_slave_port.sv */
`timescale 1ns/1ps
module test_smbus_temp_sensor_slave_port;
    localparam int TO = 200;
    localparam logic [6:0] ADR = smbus_temp_pkg::SLAVE_ADDR_DEF;
    logic clk_sys = 1'h0;
    logic rst = 1'h1;
    logic conv_done = 1'h0;
    logic conv_busy = 1'h0;
    logic [11:0] local_raw = 12'h000;
    logic [13:0] remote1_raw = 14'h0000;
    logic [13:0] remote2_raw = 14'h0000;
    logic [1:0] diode_open = 2'h0;
    logic [1:0] diode_short_dminus = 2'h0;
    logic scl, host_low, sda, sda_out, sda_oe_n, standby, oneshot_start;
    logic [1:0] filter_on, model_sel, comp_mode_on;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int pulses = 0;
    // open-drain data line with pull-up
    assign sda = ~(host_low | ~sda_oe_n);
    always #12.5 clk_sys = ~clk_sys;
    smbus_temp_sensor_slave_port #(.TIMEOUT_CYCLES(TO)) i_dut (
        .clk_sys(clk_sys), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
        .sda_oe_n(sda_oe_n), .conv_done(conv_done), .conv_busy(conv_busy),
        .local_raw(local_raw), .remote1_raw(remote1_raw), .remote2_raw(remote2_raw),
        .diode_open(diode_open), .diode_short_dminus(diode_short_dminus),
        .standby(standby), .oneshot_start(oneshot_start), .filter_on(filter_on),
        .model_sel(model_sel), .comp_mode_on(comp_mode_on)
    );
    smbus_host_model #(.ADDR(ADR)) i_host (
        .clk_sys(clk_sys), .sda(sda), .scl(scl), .sda_low(host_low)
    );
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        if (oneshot_start === 1'h1)
            pulses <= pulses + 1;
        if (cyc == 40000)
        begin
            bad_count++;
            complete_run();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, got);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic rchk(input logic [7:0] cmd, exp);
        logic [15:0] d;
        logic ok;
        i_host.rd(cmd, 1'h1, 1, d, ok);
        chk($sformatf("reg %h", cmd), {exp, 7'h00, 1'h1}, {d[15:8], 7'h00, ok});
    endtask
    task automatic wr(input logic [7:0] cmd, dat, input logic full);
        logic ok;
        i_host.wr(cmd, dat, full, ok);
        chk("write ack", 16'h0001, {15'h0000, ok});
    endtask
    task automatic conv(input logic [11:0] l, input logic [13:0] r1, r2,
        input logic [1:0] op, sh);
        local_raw = l;
        remote1_raw = r1;
        remote2_raw = r2;
        diode_open = op;
        diode_short_dminus = sh;
        conv_done = 1'h1;
        tick(1);
        conv_done = 1'h0;
        tick(2);
    endtask
    task automatic t_reset();
        logic [15:0] d;
        logic ok;
        chk("controls", 16'h0035, {9'h000, standby, filter_on, model_sel, comp_mode_on});
        i_host.rd(8'h00, 1'h0, 1, d, ok);
        chk("ptr 00", 16'h0001, {d[15:8], 7'h00, ok});
        rchk(8'h03, 8'h00);
        rchk(8'h06, 8'h05);
        rchk(8'h30, 8'h01);
        rchk(8'h07, 8'h01);
        $display("t_reset done");
    endtask
    task automatic t_format();
        conv(12'hFFF, 14'h0C85, 14'h0C85, 2'h0, 2'h0);
        rchk(8'h10, 8'hFF);
        rchk(8'h20, 8'hC0);
        rchk(8'h11, 8'h64);
        rchk(8'h21, 8'h28);
        wr(8'h06, 8'h01, 1'h1);
        wr(8'h03, 8'h02, 1'h1);
        chk("filter_on", 16'h0001, {14'h0000, filter_on});
        conv(12'h3FF, 14'h1F41, 14'h0C85, 2'h0, 2'h0);
        rchk(8'h10, 8'h7F);
        rchk(8'h20, 8'hC0);
        rchk(8'h11, 8'hFA);
        rchk(8'h21, 8'h08);
        rchk(8'h12, 8'h64);
        rchk(8'h22, 8'h20);
        $display("t_format done");
    endtask
    task automatic t_fault();
        conv(12'h064, 14'h0000, 14'h0000, 2'h1, 2'h0);
        rchk(8'h11, 8'hFF);
        rchk(8'h21, 8'hE0);
        rchk(8'h02, 8'h05);
        conv(12'h064, 14'h0000, 14'h0000, 2'h0, 2'h3);
        conv_busy = 1'h1;
        rchk(8'h02, 8'h86);
        conv_busy = 1'h0;
        rchk(8'h12, 8'h80);
        rchk(8'h22, 8'h00);
        rchk(8'h11, 8'h00);
        $display("t_fault done");
    endtask
    task automatic t_lock();
        conv(12'h064, 14'h0101, 14'h0000, 2'h0, 2'h0);
        rchk(8'h11, 8'h08);
        conv(12'h064, 14'h0202, 14'h0000, 2'h0, 2'h0);
        rchk(8'h21, 8'h08);
        rchk(8'h21, 8'h10);
        rchk(8'h11, 8'h10);
        conv(12'h064, 14'h0303, 14'h0000, 2'h0, 2'h0);
        rchk(8'h11, 8'h18);
        conv(12'h064, 14'h0404, 14'h0000, 2'h0, 2'h0);
        rchk(8'h21, 8'h18);
        $display("t_lock done");
    endtask
    task automatic t_pointer();
        logic [15:0] d;
        logic ok;
        wr(8'h03, 8'h40, 1'h0);
        chk("standby", 16'h0000, {15'h0000, standby});
        i_host.rd(8'h00, 1'h0, 2, d, ok);
        chk("ptr 03 twice", 16'h0202, d);
        i_host.rd(8'h00, 1'h0, 1, d, ok);
        chk("ptr 03 again", 16'h0201, {d[15:8], 7'h00, ok});
        rchk(8'h55, 8'h00);
        $display("t_pointer done");
    endtask
    task automatic t_oneshot();
        wr(8'h0F, 8'hA5, 1'h1);
        tick(4);
        chk("no pulse", 16'h0000, pulses[15:0]);
        wr(8'h03, 8'h42, 1'h1);
        chk("standby", 16'h0001, {15'h0000, standby});
        wr(8'h0F, 8'hA5, 1'h1);
        tick(4);
        chk("pulse", 16'h0001, pulses[15:0]);
        rchk(8'h0F, 8'h00);
        $display("t_oneshot done");
    endtask
    task automatic t_restart();
        logic r;
        i_host.start();
        i_host.byte_out({ADR, 1'h0}, r);
        repeat (3) i_host.bit_io(1'h1, r);
        wr(8'h03, 8'h02, 1'h1);
        chk("standby", 16'h0000, {15'h0000, standby});
        rchk(8'h03, 8'h02);
        $display("t_restart done");
    endtask
    task automatic t_timeout();
        logic r;
        wr(8'h10, 8'h00, 1'h0);
        i_host.start();
        i_host.byte_out({ADR, 1'h1}, r);
        tick(6);
        chk("held low", 16'h0000, {14'h0000, sda_oe_n, sda_out});
        i_host.tick(TO + 10);
        chk("released", 16'h0002, {14'h0000, sda_oe_n, sda_out});
        rchk(8'h10, 8'h19);
        $display("t_timeout done");
    endtask
    initial
    begin
        tick(2);
        rst = 1'h0;
        tick(4);
        t_reset();
        t_format();
        t_fault();
        t_lock();
        t_pointer();
        t_oneshot();
        t_restart();
        t_timeout();
        complete_run();
    end
endmodule

/* File: rtl/smbus_temp_pkg.sv */
package smbus_temp_pkg;
    // register pointer values
    localparam logic [7:0] PTR_RESET = 8'h00;
    localparam logic [7:0] PTR_STATUS = 8'h02;
    localparam logic [7:0] PTR_CONFIG = 8'h03;
    localparam logic [7:0] PTR_FILTER = 8'h06;
    localparam logic [7:0] PTR_COMP_MODE = 8'h07;
    localparam logic [7:0] PTR_ONESHOT = 8'h0F;
    localparam logic [7:0] PTR_LOCAL_MSB = 8'h10;
    localparam logic [7:0] PTR_REM1_MSB = 8'h11;
    localparam logic [7:0] PTR_REM2_MSB = 8'h12;
    localparam logic [7:0] PTR_LOCAL_LSB = 8'h20;
    localparam logic [7:0] PTR_REM1_LSB = 8'h21;
    localparam logic [7:0] PTR_REM2_LSB = 8'h22;
    localparam logic [7:0] PTR_MODEL = 8'h30;
    localparam logic [7:0] PTR_MFR_ID = 8'hFE;
    localparam logic [7:0] PTR_REV_ID = 8'hFF;
    // reset values
    localparam logic [7:0] CONFIG_RST = 8'h00;
    localparam logic [7:0] FILTER_RST = 8'h05;
    localparam logic [7:0] MODEL_RST = 8'h01;
    localparam logic [7:0] COMP_MODE_RST = 8'h01;
    // field positions
    localparam int CFG_UNSIGNED1_BIT = 1;
    localparam int CFG_UNSIGNED2_BIT = 2;
    localparam int CFG_STANDBY_BIT = 6;
    localparam int FILT1_BIT = 0;
    localparam int FILT2_BIT = 2;
    localparam int ST_BUSY_BIT = 7;
    // temperature word formats
    localparam logic [15:0] REM_FAULT_SIGNED = 16'h8000;
    localparam logic [15:0] REM_FAULT_UNSIGNED = 16'hFFE0;
    localparam logic [15:0] MASK_FILT_ON = 16'hFFF8;
    localparam logic [15:0] MASK_FILT_OFF = 16'hFFE0;
    localparam logic [9:0] LOCAL_MAX = 10'h1FF;
    localparam logic [9:0] LOCAL_MIN = 10'h200;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    // timing
    localparam int TIMEOUT_MS = 35;
    localparam int CLK_HZ = 40000000;
    localparam int TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);
    // identity values are arbitrary
    localparam logic [6:0] SLAVE_ADDR_DEF = 7'h2B;
    localparam logic [7:0] MFR_ID_DEF = 8'h5A;
    localparam logic [7:0] REV_ID_DEF = 8'h3C;

    typedef enum logic [9:0] {
        ST_IDLE = 10'h001,
        ST_ADDR = 10'h002,
        ST_ADDR_ACK = 10'h004,
        ST_CMD = 10'h008,
        ST_CMD_ACK = 10'h010,
        ST_WDATA = 10'h020,
        ST_WDATA_ACK = 10'h040,
        ST_RDATA = 10'h080,
        ST_RDATA_ACK = 10'h100,
        ST_IGNORE = 10'h200
    } bus_state_t;
endpackage

/* File: rtl/smbus_temp_sensor_slave_port.sv */
`timescale 1ns/1ps
module smbus_temp_sensor_slave_port #(
    parameter int TIMEOUT_CYCLES = smbus_temp_pkg::TIMEOUT_CYC,
    parameter logic [6:0] SLAVE_ADDR = smbus_temp_pkg::SLAVE_ADDR_DEF,
    parameter logic [7:0] MFR_ID = smbus_temp_pkg::MFR_ID_DEF,
    parameter logic [7:0] REV_ID = smbus_temp_pkg::REV_ID_DEF
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // conversion results
    input wire logic conv_done,
    input wire logic conv_busy,
    input wire logic [11:0] local_raw,
    input wire logic [13:0] remote1_raw,
    input wire logic [13:0] remote2_raw,
    input wire logic [1:0] diode_open,
    input wire logic [1:0] diode_short_dminus,
    // conversion control
    output logic standby,
    output logic oneshot_start,
    output logic [1:0] filter_on,
    output logic [1:0] model_sel,
    output logic [1:0] comp_mode_on
);
    localparam int TO_W = $clog2(TIMEOUT_CYCLES + 1);

    // clamp, fault-force and mask one remote reading
    function automatic logic [15:0] rem_word(input logic [13:0] raw, input logic uns,
                                             input logic filt, input logic fault);
        logic [12:0] c;
        c = raw[12:0];
        if (uns && raw[13])
            c = '0;
        else if (!uns && raw[13] != raw[12])
            c = raw[13] ? {1'b1, 12'h000} : {1'b0, 12'hFFF};
        if (fault)
            rem_word = uns ? smbus_temp_pkg::REM_FAULT_UNSIGNED
                           : smbus_temp_pkg::REM_FAULT_SIGNED;
        else
            rem_word = {c, 3'h0} & (filt ? smbus_temp_pkg::MASK_FILT_ON
                                         : smbus_temp_pkg::MASK_FILT_OFF);
    endfunction

    logic scl_s1_q, scl_s2_q, scl_s3_q, sda_s1_q, sda_s2_q, sda_s3_q;
    smbus_temp_pkg::bus_state_t state_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shift_q, tx_q, ptr_q, config_q, filter_q, model_q, comp_mode_q;
    logic rnw_q, nack_q, oe_n_q, oneshot_q;
    logic [TO_W-1:0] to_cnt_q;
    logic [9:0] local_q;
    logic [15:0] remote_q [2];
    logic [1:0] miss_q, lock_q;
    logic [7:0] lk_byte_q [2];
    logic [7:0] rd_byte;

    // synchronisers; the third stage only feeds edge detection
    // reset to the idle bus level so no false edge follows reset
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            scl_s1_q <= 1'b1;
            scl_s2_q <= 1'b1;
            scl_s3_q <= 1'b1;
            sda_s1_q <= 1'b1;
            sda_s2_q <= 1'b1;
            sda_s3_q <= 1'b1;
        end
        else
        begin
            scl_s1_q <= scl_in;
            scl_s2_q <= scl_s1_q;
            scl_s3_q <= scl_s2_q;
            sda_s1_q <= sda_in;
            sda_s2_q <= sda_s1_q;
            sda_s3_q <= sda_s2_q;
        end
    end

    wire scl_rise = scl_s2_q && !scl_s3_q;
    wire scl_fall = !scl_s2_q && scl_s3_q;
    wire start_evt = scl_s2_q && scl_s3_q && !sda_s2_q && sda_s3_q;
    wire stop_evt = scl_s2_q && scl_s3_q && sda_s2_q && !sda_s3_q;
    wire bus_low = !scl_s2_q || !sda_s2_q;
    wire to_fire = bus_low && (to_cnt_q == TO_W'(TIMEOUT_CYCLES));
    wire receiving = state_q == smbus_temp_pkg::ST_ADDR || state_q == smbus_temp_pkg::ST_CMD
                     || state_q == smbus_temp_pkg::ST_WDATA;
    wire byte_in = scl_fall && bit_cnt_q == smbus_temp_pkg::BITS_PER_BYTE;
    wire addr_hit = shift_q[7:1] == SLAVE_ADDR;
    wire cmd_stb = byte_in && state_q == smbus_temp_pkg::ST_CMD;
    wire wr_stb = byte_in && state_q == smbus_temp_pkg::ST_WDATA;
    wire rd_load = scl_fall && ((state_q == smbus_temp_pkg::ST_ADDR_ACK && rnw_q)
                   || (state_q == smbus_temp_pkg::ST_RDATA_ACK && !nack_q));
    wire [1:0] uns_sel = {config_q[smbus_temp_pkg::CFG_UNSIGNED2_BIT],
                          config_q[smbus_temp_pkg::CFG_UNSIGNED1_BIT]};
    wire [1:0] filt_sel = {filter_q[smbus_temp_pkg::FILT2_BIT],
                           filter_q[smbus_temp_pkg::FILT1_BIT]};
    wire [1:0] fault = diode_open | (diode_short_dminus & ~comp_mode_q[1:0]);
    wire local_ovf = local_raw[11:9] != {3{local_raw[9]}};
    wire [9:0] local_clamp = !local_ovf ? local_raw[9:0]
                             : (local_raw[11] ? smbus_temp_pkg::LOCAL_MIN
                                              : smbus_temp_pkg::LOCAL_MAX);

    // timeout: bus held low past the limit
    always_ff @(posedge clk_sys)
    begin
        if (rst || !bus_low)
            to_cnt_q <= '0;
        else if (!to_fire)
            to_cnt_q <= to_cnt_q + 1'b1;
    end

    // read selection; temperature low bytes carry zeros in unused bits
    always_comb
    begin
        case (ptr_q)
            smbus_temp_pkg::PTR_RESET, smbus_temp_pkg::PTR_LOCAL_MSB: rd_byte = local_q[9:2];
            smbus_temp_pkg::PTR_LOCAL_LSB: rd_byte = {local_q[1:0], 6'h00};
            smbus_temp_pkg::PTR_REM1_MSB: rd_byte = remote_q[0][15:8];
            smbus_temp_pkg::PTR_REM2_MSB: rd_byte = remote_q[1][15:8];
            smbus_temp_pkg::PTR_REM1_LSB: rd_byte = lock_q[0] ? lk_byte_q[0] : remote_q[0][7:0];
            smbus_temp_pkg::PTR_REM2_LSB: rd_byte = lock_q[1] ? lk_byte_q[1] : remote_q[1][7:0];
            smbus_temp_pkg::PTR_STATUS: rd_byte = {conv_busy, 3'h0, comp_mode_q[1:0], miss_q};
            smbus_temp_pkg::PTR_CONFIG: rd_byte = config_q;
            smbus_temp_pkg::PTR_FILTER: rd_byte = filter_q;
            smbus_temp_pkg::PTR_COMP_MODE: rd_byte = comp_mode_q;
            smbus_temp_pkg::PTR_MODEL: rd_byte = model_q;
            smbus_temp_pkg::PTR_MFR_ID: rd_byte = MFR_ID;
            smbus_temp_pkg::PTR_REV_ID: rd_byte = REV_ID;
            default: rd_byte = 8'h00;
        endcase
    end

    // bus state machine; samples on scl rise, changes sda after scl fall
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_q <= smbus_temp_pkg::ST_IDLE;
            bit_cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'h00;
            rnw_q <= 1'b0;
            nack_q <= 1'b1;
            oe_n_q <= 1'b1;
        end
        else if (to_fire || stop_evt)
        begin
            state_q <= smbus_temp_pkg::ST_IDLE;
            oe_n_q <= 1'b1;
        end
        else if (start_evt)
        begin
            state_q <= smbus_temp_pkg::ST_ADDR;
            bit_cnt_q <= 4'h0;
            oe_n_q <= 1'b1;
        end
        else if (scl_rise)
        begin
            shift_q <= {shift_q[6:0], sda_s2_q};
            nack_q <= sda_s2_q;
            if (receiving)
                bit_cnt_q <= bit_cnt_q + 4'h1;
        end
        else if (scl_fall)
        begin
            case (state_q)
                smbus_temp_pkg::ST_ADDR:
                    if (byte_in)
                    begin
                        state_q <= addr_hit ? smbus_temp_pkg::ST_ADDR_ACK
                                            : smbus_temp_pkg::ST_IGNORE;
                        oe_n_q <= !addr_hit;
                        rnw_q <= shift_q[0];
                    end
                smbus_temp_pkg::ST_ADDR_ACK:
                begin
                    bit_cnt_q <= 4'h0;
                    state_q <= rnw_q ? smbus_temp_pkg::ST_RDATA : smbus_temp_pkg::ST_CMD;
                    tx_q <= rd_byte;
                    oe_n_q <= rnw_q ? rd_byte[7] : 1'b1;
                end
                smbus_temp_pkg::ST_CMD:
                    if (byte_in)
                    begin
                        state_q <= smbus_temp_pkg::ST_CMD_ACK;
                        oe_n_q <= 1'b0;
                    end
                smbus_temp_pkg::ST_CMD_ACK:
                begin
                    state_q <= smbus_temp_pkg::ST_WDATA;
                    bit_cnt_q <= 4'h0;
                    oe_n_q <= 1'b1;
                end
                smbus_temp_pkg::ST_WDATA:
                    if (byte_in)
                    begin
                        state_q <= smbus_temp_pkg::ST_WDATA_ACK;
                        oe_n_q <= 1'b0;
                    end
                smbus_temp_pkg::ST_WDATA_ACK:
                begin
                    state_q <= smbus_temp_pkg::ST_IGNORE;
                    oe_n_q <= 1'b1;
                end
                smbus_temp_pkg::ST_RDATA:
                    if (bit_cnt_q == 4'h7)
                    begin
                        state_q <= smbus_temp_pkg::ST_RDATA_ACK;
                        oe_n_q <= 1'b1;
                    end
                    else
                    begin
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        tx_q <= {tx_q[6:0], 1'b0};
                        oe_n_q <= tx_q[6];
                    end
                smbus_temp_pkg::ST_RDATA_ACK:
                begin
                    state_q <= nack_q ? smbus_temp_pkg::ST_IGNORE
                                      : smbus_temp_pkg::ST_RDATA;
                    bit_cnt_q <= 4'h0;
                    tx_q <= rd_byte;
                    oe_n_q <= nack_q ? 1'b1 : rd_byte[7];
                end
                default:
                    state_q <= state_q;
            endcase
        end
    end

    // pointer and writable registers
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ptr_q <= smbus_temp_pkg::PTR_RESET;
            config_q <= smbus_temp_pkg::CONFIG_RST;
            filter_q <= smbus_temp_pkg::FILTER_RST;
            model_q <= smbus_temp_pkg::MODEL_RST;
            comp_mode_q <= smbus_temp_pkg::COMP_MODE_RST;
            oneshot_q <= 1'b0;
        end
        else
        begin
            if (cmd_stb)
                ptr_q <= shift_q;
            if (wr_stb && ptr_q == smbus_temp_pkg::PTR_CONFIG)
                config_q <= shift_q;
            if (wr_stb && ptr_q == smbus_temp_pkg::PTR_FILTER)
                filter_q <= shift_q;
            if (wr_stb && ptr_q == smbus_temp_pkg::PTR_MODEL)
                model_q <= shift_q;
            if (wr_stb && ptr_q == smbus_temp_pkg::PTR_COMP_MODE)
                comp_mode_q <= shift_q;
            oneshot_q <= wr_stb && ptr_q == smbus_temp_pkg::PTR_ONESHOT
                         && config_q[smbus_temp_pkg::CFG_STANDBY_BIT];
        end
    end

    // conversion results and low-byte freeze
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            local_q <= 10'h000;
            miss_q <= 2'b00;
            lock_q <= 2'b00;
            for (int i = 0; i < 2; i++)
            begin
                remote_q[i] <= 16'h0000;
                lk_byte_q[i] <= 8'h00;
            end
        end
        else
        begin
            if (conv_done)
            begin
                local_q <= local_clamp;
                miss_q <= fault;
                remote_q[0] <= rem_word(remote1_raw, uns_sel[0], filt_sel[0], fault[0]);
                remote_q[1] <= rem_word(remote2_raw, uns_sel[1], filt_sel[1], fault[1]);
            end
            for (int i = 0; i < 2; i++)
            begin
                if (rd_load && ptr_q == smbus_temp_pkg::PTR_REM1_MSB + 8'(i))
                begin
                    lock_q[i] <= 1'b1;
                    lk_byte_q[i] <= remote_q[i][7:0];
                end
                else if (rd_load && ptr_q == smbus_temp_pkg::PTR_REM1_LSB + 8'(i))
                    lock_q[i] <= 1'b0;
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe_n = oe_n_q;
    assign standby = config_q[smbus_temp_pkg::CFG_STANDBY_BIT];
    assign oneshot_start = oneshot_q;
    assign filter_on = filt_sel;
    assign model_sel = model_q[1:0];
    assign comp_mode_on = comp_mode_q[1:0];

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    a_timeout_idle: assert property (to_fire |=> state_q == smbus_temp_pkg::ST_IDLE && sda_oe_n)
        else $error("timeout did not return bus to idle");
    a_start_restart: assert property (start_evt && !to_fire |=>
        state_q == smbus_temp_pkg::ST_ADDR && bit_cnt_q == 4'h0 && sda_oe_n)
        else $error("start did not restart address phase");
    a_cmd_loads_ptr: assert property (cmd_stb |=> ptr_q == $past(shift_q))
        else $error("command byte not loaded into pointer");
    a_ptr_holds: assert property (!cmd_stb |=> $stable(ptr_q))
        else $error("pointer changed without command byte");
    a_oneshot_fires: assert property (wr_stb && ptr_q == smbus_temp_pkg::PTR_ONESHOT
        |=> oneshot_start == $past(standby))
        else $error("one-shot pulse wrong");
    a_local_clamp: assert property (conv_done && !local_raw[11] && local_ovf
        |=> local_q == smbus_temp_pkg::LOCAL_MAX)
        else $error("local reading not clamped");
    a_fault_force: assert property (conv_done && fault[0] |=> miss_q[0] && remote_q[0] ==
        ($past(uns_sel[0]) ? 16'hFFE0 : 16'h8000))
        else $error("remote fault not forced");
    a_nack_release: assert property (scl_fall && !start_evt && !stop_evt && !to_fire
        && state_q == smbus_temp_pkg::ST_RDATA_ACK && nack_q
        |=> (state_q == smbus_temp_pkg::ST_IGNORE && sda_oe_n) [*2])
        else $error("nack did not end transmission");
    a_unused_zero: assert property (remote_q[0][2:0] == 3'h0 && remote_q[1][2:0] == 3'h0)
        else $error("unused remote bits not zero");
    a_lsb_frozen: assert property (lock_q[0] && !rd_load |=> lock_q[0]
        && lk_byte_q[0] == $past(lk_byte_q[0]))
        else $error("frozen low byte changed");
endmodule
